// file: logic/plc_cfg.svh
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH
// ************************************************************
// Clock and time base
// ************************************************************
`define PLC_CLK_HZ 25000000
`define PLC_US_CYC(us) ((us) * (`PLC_CLK_HZ / 1000000))
`define PLC_BAUD_CYC(b) (`PLC_CLK_HZ / (b))
// ************************************************************
// Baud rates and detection times
// ************************************************************
`define PLC_BAUD_0 600
`define PLC_BAUD_1 1200
`define PLC_BAUD_2 2400
`define PLC_BAUD_3 4800
`define PLC_DET_T0_US 500
`define PLC_DET_T1_US 1000
`define PLC_DET_T2_US 3000
`define PLC_DET_T3_US 5000
// ************************************************************
// Clock recovery, detection and level control
// ************************************************************
`define PLC_RUN_MAX 32
`define PLC_LOCK_EDGES 2
`define PLC_PRE_TOGGLES 3
`define PLC_WORD_BITS 16
`define PLC_TRIM_MAX 64
`define PLC_ALC_TICK_HZ 5000
`define PLC_ALC_CYC (`PLC_CLK_HZ / `PLC_ALC_TICK_HZ)
`define PLC_GAIN_MAX 5'h1F
`define PLC_FIFO_DEPTH 16
// ************************************************************
// Synchroniser bit positions
// ************************************************************
`define PLC_SYNC_W 11
`define PLC_S_DIR 0
`define PLC_S_REG 1
`define PLC_S_UART 2
`define PLC_S_DEM 3
`define PLC_S_CAR 4
`define PLC_S_TONE 5
`define PLC_S_TXD 6
`define PLC_S_VLO 7
`define PLC_S_VHI 8
`define PLC_S_CHI 9
`define PLC_S_CLO 10
`endif

// file: logic/plc_pkg.sv
`default_nettype none
// ************************************************************
// Shared types
// ************************************************************
package plc_pkg;
	typedef struct packed {
		logic [10:0] s1;
		logic [10:0] s2;
		logic [15:0] ph;
		logic signed [7:0] trim;
		logic locked;
		logic [1:0] good_cnt;
		logic prev_d;
		logic [5:0] run_cnt;
		logic last_bit;
		logic [1:0] alt_cnt;
		logic pre_seen;
		logic filt;
		logic [16:0] det_cnt;
		logic [15:0] hdr_sr;
		logic frame_active;
		logic [11:0] bits_left;
		logic hdr_pulse;
		logic out_bit;
		logic bclk_o;
		logic rxd_o;
		logic dn_o;
		logic mod_en;
		logic tx_bit;
		logic [12:0] tick_cnt;
		logic [4:0] gain;
	} plc_top_state_t;
endpackage : plc_pkg
`default_nettype wire

// file: logic/plc_modem.sv
`timescale 1ns/1ps
`default_nettype none
`include "plc_cfg.svh"
// ************************************************************
// Bit FIFO between the sampler and the host output
// ************************************************************
module plc_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} plc_fifo_state_t;
	plc_fifo_state_t r;
	plc_fifo_state_t n;
	logic [WIDTH-1:0] mem [DEPTH];
	// Extra pointer bit tells full from empty; depth must be a power of two
	assign in_ready = !((r.wr[AW] != r.rd[AW]) && (r.wr[AW-1:0] == r.rd[AW-1:0]));
	assign out_valid = (r.wr != r.rd);
	assign out_data = mem[r.rd[AW-1:0]];
	// Pointer update, flush wins
	always_comb begin
		n = r;
		if (flush) begin
			n = '0;
		end else begin
			if (in_valid && in_ready) begin
				n.wr = r.wr + 1'b1;
			end
			if (out_valid && out_ready) begin
				n.rd = r.rd + 1'b1;
			end
		end
	end
	// State and storage
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
		if (in_valid && in_ready && !flush) begin
			mem[r.wr[AW-1:0]] <= in_data;
		end
	end
endmodule : plc_fifo

// Notes on behaviour
// - Receive data stable at recovered clock rise; clock falls on data transitions.
// - While unlocked in receive mode, recovered clock and receive data outputs are both low.
// - Unlocked loop uses both edge kinds and locks within five transitions.
// - Locked loop corrects phase on rising data edges only.
// - More than 32 equal symbols force the loop unlocked.
// - Senders avoid runs of 15 or more equal symbols, lock may drop.
// - Carrier setting: notify goes low when carrier tone present.
// - Preamble setting: flag after four alternating symbols, 1010 or 0101.
// - Preamble setting: notify low only with carrier present and loop locked.
// - Notify assertion delayed by the programmed detection time.
// - After carrier loss, notify held low one detection time, then high.
// - Header match only in extended mode with header enable; drives notify low.
// - Frame counting: notify low while delivering selected number of 16-bit words.
// - Frame counting: outside frame, clock low and data at idle level.
// - No frame counting: header match pulses notify low one bit period.
// - Direction low and register select low selects transmit; modulator on.
// - Synchronous transmit samples host data at bit clock rise, paced by baud.
// - Asynchronous transmit passes host data straight to modulator.
// - No framing bits added to transmitted data.
// - Gain index of 32 steps, changes at most once per 5 kHz tick.
// - Voltage loop raises below band, lowers above band, else holds.
// - Current above band lowers gain, overrides voltage; within band holds.
// - No mark or space tone: receive data at idle level of interface select.
// - Direction high, register select low selects receive; transmit path off.
// - Detection time select 00/01/10/11 gives 500 us, 1, 3, 5 ms.
// - Detection method select; conditioning forces clock and data low undetected.
module plc_rx_modem
	import plc_pkg::*;
#(
	parameter int unsigned BAUD_CYC_0 = `PLC_BAUD_CYC(`PLC_BAUD_0),
	parameter int unsigned BAUD_CYC_1 = `PLC_BAUD_CYC(`PLC_BAUD_1),
	parameter int unsigned BAUD_CYC_2 = `PLC_BAUD_CYC(`PLC_BAUD_2),
	parameter int unsigned BAUD_CYC_3 = `PLC_BAUD_CYC(`PLC_BAUD_3),
	parameter int unsigned DET_CYC_0 = `PLC_US_CYC(`PLC_DET_T0_US),
	parameter int unsigned DET_CYC_1 = `PLC_US_CYC(`PLC_DET_T1_US),
	parameter int unsigned DET_CYC_2 = `PLC_US_CYC(`PLC_DET_T2_US),
	parameter int unsigned DET_CYC_3 = `PLC_US_CYC(`PLC_DET_T3_US),
	parameter int unsigned ALC_CYC = `PLC_ALC_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Host pins
	input wire logic direction_select,
	input wire logic reg_select,
	input wire logic uart_select,
	input wire logic tx_data,
	output logic bit_clock_out,
	output logic rx_data,
	output logic detect_notify_n,
	// Demodulator and detector pins
	input wire logic demod_data,
	input wire logic carrier_present,
	input wire logic tone_present,
	// Configuration
	input wire logic [1:0] baud_sel,
	input wire logic [1:0] det_time_sel,
	input wire logic [1:0] det_method,
	input wire logic extended_mode,
	input wire logic header_enable,
	input wire logic frame_len_enable,
	input wire logic [7:0] frame_len,
	input wire logic [15:0] header_pattern,
	// Transmit and level control
	input wire logic vsense_below_band,
	input wire logic vsense_above_band,
	input wire logic current_above_band,
	input wire logic current_below_band,
	output logic modulator_en,
	output logic line_driver_en,
	output logic mod_data,
	output logic [4:0] level_ctrl_out
);
	plc_top_state_t r;
	plc_top_state_t n;
	logic rx_mode, tx_mode, dbit, edge_any, edge_rise, use_edge, wrap, sample, late, in_win;
	logic raw, tick, framing, hdr_on, hdr_match, accept, fifo_push, fifo_pop;
	logic [15:0] period, half, quarter, err;
	logic [16:0] det_t;
	logic [15:0] hdr_next;
	logic fifo_in_ready, fifo_out_valid;
	logic [0:0] fifo_out_data;

	// ************************************************************
	// Receive bit FIFO
	// ************************************************************
	plc_fifo #(.WIDTH(1), .DEPTH(`PLC_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset(reset),
		.flush(!rx_mode),
		.in_valid(fifo_push),
		.in_data(dbit),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		n = r;
		// Host, detector and sense pins pass two flip-flops; only s2 is read, except tx_data taken raw for async transmit
		n.s1 = {current_below_band, current_above_band, vsense_above_band, vsense_below_band, tx_data,
			tone_present, carrier_present, demod_data, uart_select, reg_select, direction_select};
		n.s2 = r.s1;
		rx_mode = r.s2[`PLC_S_DIR] & ~r.s2[`PLC_S_REG];
		tx_mode = ~r.s2[`PLC_S_DIR] & ~r.s2[`PLC_S_REG];
		dbit = r.s2[`PLC_S_DEM];
		// Bit period plus integrator trim makes the loop second order
		unique case (baud_sel)
			2'b00: period = 16'(BAUD_CYC_0);
			2'b01: period = 16'(BAUD_CYC_1);
			2'b10: period = 16'(BAUD_CYC_2);
			2'b11: period = 16'(BAUD_CYC_3);
		endcase
		period = period + 16'(r.trim);
		half = period >> 1;
		quarter = period >> 2;
		// Detection time select
		unique case (det_time_sel)
			2'b00: det_t = 17'(DET_CYC_0);
			2'b01: det_t = 17'(DET_CYC_1);
			2'b10: det_t = 17'(DET_CYC_2);
			2'b11: det_t = 17'(DET_CYC_3);
		endcase
		// Edge classes; locked loop looks at rising edges only
		edge_any = dbit ^ r.prev_d;
		edge_rise = dbit & ~r.prev_d;
		use_edge = rx_mode & (r.locked ? edge_rise : edge_any);
		wrap = (r.ph >= period - 16'h0001);
		sample = (r.ph == half);
		late = (r.ph < half);
		err = late ? r.ph : period - r.ph;
		in_win = (err < quarter);
		n.prev_d = dbit;
		n.ph = wrap ? 16'h0000 : r.ph + 16'h0001;
		// Phase detector; falling clock edge sits on data transitions
		if (use_edge) begin
			if (!r.locked) begin
				n.ph = 16'h0000;
				n.trim = '0;
				if (in_win && r.good_cnt == 2'(`PLC_LOCK_EDGES - 1)) begin
					n.locked = 1'b1;
					n.good_cnt = 2'h0;
				end else if (in_win) begin
					n.good_cnt = r.good_cnt + 2'h1;
				end else begin
					n.good_cnt = 2'h0;
				end
			end else if (!in_win) begin
				n.locked = 1'b0;
				n.good_cnt = 2'h0;
			end else begin
				n.ph = late ? r.ph - (err >> 1) : r.ph + (err >> 1);
				if (late && r.trim < 8'sd`PLC_TRIM_MAX) begin
					n.trim = r.trim + 8'sd1;
				end else if (!late && r.trim > -8'sd`PLC_TRIM_MAX) begin
					n.trim = r.trim - 8'sd1;
				end
			end
		end
		// Run of equal symbols counted per bit period
		if (edge_any) begin
			n.run_cnt = 6'h00;
		end else if (wrap && r.run_cnt <= 6'(`PLC_RUN_MAX)) begin
			n.run_cnt = r.run_cnt + 6'h01;
		end
		if (r.run_cnt > 6'(`PLC_RUN_MAX) || !rx_mode) begin
			n.locked = 1'b0;
			n.good_cnt = 2'h0;
		end
		// Sampling at mid bit; a sample taken while the FIFO is full is dropped
		fifo_push = sample & rx_mode;
		accept = fifo_push & fifo_in_ready;
		fifo_pop = wrap & rx_mode;
		hdr_on = extended_mode & header_enable;
		framing = hdr_on & frame_len_enable;
		hdr_next = {r.hdr_sr[14:0], dbit};
		hdr_match = accept & hdr_on & !r.frame_active & (hdr_next == header_pattern);
		if (accept) begin
			n.hdr_sr = hdr_next;
			n.last_bit = dbit;
			if (dbit != r.last_bit) begin
				if (r.alt_cnt == 2'(`PLC_PRE_TOGGLES - 1)) begin
					n.pre_seen = 1'b1;
				end else begin
					n.alt_cnt = r.alt_cnt + 2'h1;
				end
			end else begin
				n.alt_cnt = 2'h0;
			end
		end
		if (!r.s2[`PLC_S_CAR] || !r.locked) begin
			n.pre_seen = 1'b0;
			n.alt_cnt = 2'h0;
		end
		// Raw detection per method
		raw = det_method[1] ? (r.pre_seen & r.s2[`PLC_S_CAR] & r.locked) : r.s2[`PLC_S_CAR];
		// Filter: assert after det_t of raw, release det_t after loss
		if (!r.filt) begin
			if (!raw) begin
				n.det_cnt = 17'h00000;
			end else if (r.det_cnt >= det_t - 17'h00001) begin
				n.filt = 1'b1;
				n.det_cnt = 17'h00000;
			end else begin
				n.det_cnt = r.det_cnt + 17'h00001;
			end
		end else begin
			if (raw) begin
				n.det_cnt = 17'h00000;
			end else if (r.det_cnt >= det_t - 17'h00001) begin
				n.filt = 1'b0;
				n.det_cnt = 17'h00000;
			end else begin
				n.det_cnt = r.det_cnt + 17'h00001;
			end
		end
		// Header pulse lasts from one sample to the next: one bit period
		if (hdr_match && !frame_len_enable) begin
			n.hdr_pulse = 1'b1;
		end else if (sample) begin
			n.hdr_pulse = 1'b0;
		end
		// Output bit leaves the FIFO on the falling clock edge
		if (fifo_pop && fifo_out_valid) begin
			n.out_bit = fifo_out_data[0];
			if (r.frame_active) begin
				n.bits_left = r.bits_left - 12'h001;
				if (r.bits_left == 12'h001) begin
					n.frame_active = 1'b0;
				end
			end
		end
		if (hdr_match && frame_len_enable && frame_len != 8'h00) begin
			n.frame_active = 1'b1;
			n.bits_left = 12'(frame_len * `PLC_WORD_BITS);
		end
		if (!rx_mode || !framing) begin
			n.frame_active = 1'b0;
		end
		// Host outputs, registered; unlock has priority
		n.rxd_o = 1'b0;
		n.bclk_o = 1'b0;
		n.dn_o = 1'b1;
		if (tx_mode) begin
			n.bclk_o = (r.ph >= half);
		end else if (!rx_mode) begin
			n.bclk_o = 1'b0;
		end else if (!r.locked) begin
			n.bclk_o = 1'b0;
		end else if (framing && !r.frame_active) begin
			n.rxd_o = r.s2[`PLC_S_UART];
		end else if (det_method[0] && !r.filt) begin
			n.bclk_o = 1'b0;
		end else begin
			n.bclk_o = (r.ph >= half);
			n.rxd_o = r.s2[`PLC_S_TONE] ? r.out_bit : r.s2[`PLC_S_UART];
		end
		if (rx_mode) begin
			n.dn_o = hdr_on ? (frame_len_enable ? !r.frame_active : !r.hdr_pulse) : !r.filt;
		end
		// Transmit: bit taken at clock rise, no framing added
		n.mod_en = tx_mode;
		if (tx_mode && sample) begin
			n.tx_bit = r.s2[`PLC_S_TXD];
		end
		// Level control; current loop overrides voltage loop
		tick = (r.tick_cnt == 13'h0000);
		n.tick_cnt = tick ? 13'(ALC_CYC - 1) : r.tick_cnt - 13'h0001;
		if (tick && tx_mode) begin
			if (r.s2[`PLC_S_CHI]) begin
				if (r.gain != 5'h00) begin
					n.gain = r.gain - 5'h01;
				end
			end else if (!r.s2[`PLC_S_CLO]) begin
				n.gain = r.gain;
			end else if (r.s2[`PLC_S_VLO] && r.gain != `PLC_GAIN_MAX) begin
				n.gain = r.gain + 5'h01;
			end else if (r.s2[`PLC_S_VHI] && r.gain != 5'h00) begin
				n.gain = r.gain - 5'h01;
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
			r.dn_o <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Async transmit bypasses all sampling so the host owns the timing
	assign mod_data = r.mod_en & (r.s2[`PLC_S_UART] ? tx_data : r.tx_bit);
	assign bit_clock_out = r.bclk_o;
	assign rx_data = r.rxd_o;
	assign detect_notify_n = r.dn_o;
	assign modulator_en = r.mod_en;
	assign line_driver_en = r.mod_en;
	assign level_ctrl_out = r.gain;

	// ************************************************************
	// Checks
	// ************************************************************
	unlock_low_a: assert property (@(posedge clk) disable iff (reset)
		(rx_mode && !r.locked) |=> (!bit_clock_out && !rx_data)) else $error("outputs not low while unlocked");
	run_limit_a: assert property (@(posedge clk) disable iff (reset)
		(r.run_cnt > 6'(`PLC_RUN_MAX)) |=> !r.locked) else $error("long run did not unlock");
	lock_gain_a: assert property (@(posedge clk) disable iff (reset)
		(use_edge && !r.locked && in_win && r.good_cnt == 2'(`PLC_LOCK_EDGES - 1)
		&& rx_mode && r.run_cnt <= 6'(`PLC_RUN_MAX)) |=> r.locked) else $error("lock not reached");
	fall_ignored_a: assert property (@(posedge clk) disable iff (reset)
		(r.locked && rx_mode && edge_any && !edge_rise && !wrap) |=> (r.ph == $past(r.ph) + 16'h0001))
		else $error("falling edge moved phase while locked");
	filter_restart_a: assert property (@(posedge clk) disable iff (reset)
		(!r.filt && !raw) |=> (r.det_cnt == 17'h00000)) else $error("filter did not restart");
	header_pulse_a: assert property (@(posedge clk) disable iff (reset)
		(hdr_match && !frame_len_enable && rx_mode) |=> r.hdr_pulse ##1 (!detect_notify_n))
		else $error("header pulse missing");
	async_pass_a: assert property (@(posedge clk) disable iff (reset)
		(r.mod_en && r.s2[`PLC_S_UART]) |-> (mod_data == tx_data)) else $error("async data not passed");
	gain_tick_a: assert property (@(posedge clk) disable iff (reset)
		!tick |=> $stable(r.gain)) else $error("gain moved between ticks");
	current_dec_a: assert property (@(posedge clk) disable iff (reset)
		(tick && tx_mode && r.s2[`PLC_S_CHI] && r.gain != 5'h00) |=> (r.gain == $past(r.gain) - 5'h01))
		else $error("current loop did not lower gain");
	tx_enable_a: assert property (@(posedge clk) disable iff (reset)
		tx_mode |=> (modulator_en && line_driver_en)) else $error("transmit path not enabled");
	frame_gate_a: assert property (@(posedge clk) disable iff (reset)
		(rx_mode && r.locked && framing && !r.frame_active) |=> (!bit_clock_out && rx_data == $past(r.s2[`PLC_S_UART])))
		else $error("clock or data not idle outside frame");
endmodule : plc_rx_modem
`default_nettype wire

// file: verification/plc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Line side model: demodulator output and tone detectors
// ************************************************************
module plc_line_model #(
	parameter int unsigned BIT_CYC = 32
) (
	// Clock
	input wire logic clk,
	// Demodulator side
	output logic demod_data,
	output logic carrier_present,
	output logic tone_present
);
	int run;
	// Quiet line at time zero
	initial begin
		demod_data = 1'b0;
		carrier_present = 1'b0;
		tone_present = 1'b0;
		run = 0;
	end
	// Tone on or off; without tone the demodulated bit is not held
	task automatic line_on(input logic on);
		@(negedge clk);
		carrier_present = on;
		tone_present = on;
		if (!on) demod_data = ~demod_data;
	endtask : line_on
	// One symbol per bit period; long runs broken unless asked for
	task automatic send_bit(input logic b, input logic long_ok);
		logic v;
		v = b;
		if (!long_ok && run >= 14 && v == demod_data) v = ~v;
		@(negedge clk);
		run = (v == demod_data) ? run + 1 : 1;
		demod_data = v;
		repeat (BIT_CYC - 1) @(negedge clk);
	endtask : send_bit
endmodule : plc_line_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Self-checking bench for the receive modem
// ************************************************************
module tb_top;
	localparam int unsigned BAUD_C = 32;
	localparam int unsigned ALC_C = 50;
	logic clk, reset, direction_select, reg_select, uart_select, tx_data;
	logic [1:0] baud_sel, det_time_sel, det_method;
	logic extended_mode, header_enable, frame_len_enable;
	logic [7:0] frame_len;
	logic [15:0] header_pattern;
	logic vsense_below_band, vsense_above_band, current_above_band, current_below_band;
	wire logic bit_clock_out, rx_data, detect_notify_n, demod_data, carrier_present, tone_present;
	wire logic modulator_en, line_driver_en, mod_data;
	wire logic [4:0] level_ctrl_out;
	int fail_count, num_checks, seed, rises, r0, cyc_cnt, last_chg;
	logic mon_en, gmon, prev_bclk, prev_rx, b;
	logic [4:0] prev_gain, g0;
	// Free-running 25 MHz clock
	always #20 clk = ~clk;
	// Short counts keep the run brief
	plc_rx_modem #(.BAUD_CYC_0(64), .BAUD_CYC_1(48), .BAUD_CYC_2(40), .BAUD_CYC_3(BAUD_C),
		.DET_CYC_0(20), .DET_CYC_1(40), .DET_CYC_2(60), .DET_CYC_3(80), .ALC_CYC(ALC_C)) dut (
		.clk(clk), .reset(reset), .direction_select(direction_select), .reg_select(reg_select),
		.uart_select(uart_select), .tx_data(tx_data), .bit_clock_out(bit_clock_out), .rx_data(rx_data),
		.detect_notify_n(detect_notify_n), .demod_data(demod_data), .carrier_present(carrier_present),
		.tone_present(tone_present), .baud_sel(baud_sel), .det_time_sel(det_time_sel),
		.det_method(det_method), .extended_mode(extended_mode), .header_enable(header_enable),
		.frame_len_enable(frame_len_enable), .frame_len(frame_len), .header_pattern(header_pattern),
		.vsense_below_band(vsense_below_band), .vsense_above_band(vsense_above_band),
		.current_above_band(current_above_band), .current_below_band(current_below_band),
		.modulator_en(modulator_en), .line_driver_en(line_driver_en), .mod_data(mod_data),
		.level_ctrl_out(level_ctrl_out));
	plc_line_model #(.BIT_CYC(BAUD_C)) line (.clk(clk), .demod_data(demod_data),
		.carrier_present(carrier_present), .tone_present(tone_present));
	// Detection time in cycles for a select code
	function automatic int det_cyc(input int s);
		return 20 + 20 * s;
	endfunction : det_cyc
	// One comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Verdict and end of run
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	// Watchdog sized well above the whole sequence
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		final_report();
	end
	// Monitors: data steady at clock rise, gain one step per tick at most
	always @(posedge clk) begin
		cyc_cnt++;
		if (bit_clock_out === 1'b1 && prev_bclk === 1'b0) begin
			rises++;
			if (mon_en) chk({7'h00, rx_data}, {7'h00, prev_rx}, "data moved at clock rise");
		end
		if (gmon && level_ctrl_out !== prev_gain) begin
			chk({7'h00, (level_ctrl_out == prev_gain + 5'h01) || (level_ctrl_out == prev_gain - 5'h01)},
				8'h01, "gain step size");
			chk({7'h00, cyc_cnt - last_chg >= ALC_C}, 8'h01, "gain steps too close");
			last_chg = cyc_cnt;
		end
		prev_bclk = bit_clock_out;
		prev_rx = rx_data;
		prev_gain = level_ctrl_out;
	end
	// Main sequence
	initial begin
		clk = 1'b0; reset = 1'b1; seed = 32'h868C; fail_count = 0; num_checks = 0; rises = 0;
		cyc_cnt = 0; last_chg = -1000; mon_en = 1'b0; gmon = 1'b0;
		direction_select = 1'b1; reg_select = 1'b0; uart_select = 1'b0; tx_data = 1'b0;
		baud_sel = 2'h3; det_time_sel = 2'h0; det_method = 2'h0; extended_mode = 1'b1;
		header_enable = 1'b0; frame_len_enable = 1'b0; frame_len = 8'h02; header_pattern = $random(seed);
		vsense_below_band = 1'b0; vsense_above_band = 1'b0;
		current_above_band = 1'b0; current_below_band = 1'b0;
		repeat (12) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		chk({7'h00, bit_clock_out}, 8'h00, "clock after reset");
		chk({7'h00, rx_data}, 8'h00, "data after reset");
		chk({7'h00, detect_notify_n}, 8'h01, "notify after reset");
		chk({7'h00, modulator_en}, 8'h00, "modulator in receive");
		chk({3'h0, level_ctrl_out}, 8'h00, "gain after reset");
		gmon = 1'b1;
		$display("test reset done");
		// Every detection time code, with a glitch that must restart the count
		for (int s = 0; s < 4; s++) begin
			det_time_sel = s[1:0];
			baud_sel = s[1:0];
			line.line_on(1'b1);
			cyc(det_cyc(s) / 2);
			line.line_on(1'b0);
			cyc(2);
			line.line_on(1'b1);
			cyc(det_cyc(s) - 1);
			chk({7'h00, detect_notify_n}, 8'h01, "notify before filter time");
			cyc(6);
			chk({7'h00, detect_notify_n}, 8'h00, "notify with carrier");
			line.line_on(1'b0);
			cyc(det_cyc(s) - 1);
			chk({7'h00, detect_notify_n}, 8'h00, "notify hold after loss");
			cyc(6);
			chk({7'h00, detect_notify_n}, 8'h01, "notify release");
		end
		$display("test detection time done");
		// Preamble, lock, then random run-limited data
		det_method = 2'h2;
		det_time_sel = 2'h0;
		baud_sel = 2'h3;
		line.line_on(1'b1);
		for (int i = 0; i < 8; i++) line.send_bit(i[0], 1'b0);
		r0 = rises;
		for (int i = 0; i < 8; i++) line.send_bit(i[0], 1'b0);
		chk({7'h00, rises - r0 >= 6}, 8'h01, "clock after five transitions");
		chk({7'h00, detect_notify_n}, 8'h00, "preamble notify");
		mon_en = 1'b1;
		r0 = rises;
		for (int i = 0; i < 48; i++) begin
			b = $random(seed);
			tx_data = $random(seed);
			line.send_bit(b, 1'b0);
		end
		chk({7'h00, rises - r0 >= 44}, 8'h01, "lock held on data");
		chk({7'h00, detect_notify_n}, 8'h00, "notify while locked");
		mon_en = 1'b0;
		$display("test lock done");
		// Header pulse without frame counting; pattern keeps runs short for lock
		header_pattern = 16'hB4D2;
		header_enable = 1'b1;
		for (int i = 0; i < 16; i++) line.send_bit(header_pattern[15 - i], 1'b0);
		chk({7'h00, detect_notify_n}, 8'h00, "header pulse low");
		cyc(BAUD_C);
		chk({7'h00, detect_notify_n}, 8'h01, "header pulse ends");
		// Frame of one word after a header match
		frame_len_enable = 1'b1;
		frame_len = 8'h01;
		for (int i = 0; i < 4; i++) line.send_bit(i[0], 1'b0);
		chk({7'h00, detect_notify_n}, 8'h01, "no frame before header");
		chk({7'h00, bit_clock_out}, 8'h00, "clock idle before header");
		for (int i = 0; i < 16; i++) line.send_bit(header_pattern[15 - i], 1'b0);
		chk({7'h00, detect_notify_n}, 8'h00, "notify during frame");
		for (int i = 0; i < 24; i++) line.send_bit(i[0], 1'b0);
		chk({7'h00, detect_notify_n}, 8'h01, "frame ended after one word");
		chk({7'h00, bit_clock_out}, 8'h00, "clock idle after frame");
		header_enable = 1'b0;
		frame_len_enable = 1'b0;
		$display("test header done");
		// Long run of equal symbols drops lock
		for (int i = 0; i < 40; i++) line.send_bit(1'b1, 1'b1);
		r0 = rises;
		for (int i = 0; i < 4; i++) line.send_bit(1'b1, 1'b1);
		chk({7'h00, rises == r0}, 8'h01, "clock stopped after long run");
		chk({7'h00, rx_data}, 8'h00, "data low when unlocked");
		chk({7'h00, detect_notify_n}, 8'h01, "notify gone without lock");
		$display("test long run done");
		// Transmit, asynchronous pass-through
		line.line_on(1'b0);
		direction_select = 1'b0;
		uart_select = 1'b1;
		cyc(6);
		chk({7'h00, modulator_en}, 8'h01, "modulator on");
		chk({7'h00, line_driver_en}, 8'h01, "driver on");
		for (int i = 0; i < 8; i++) begin
			@(negedge clk) tx_data = $random(seed);
			#1 chk({7'h00, mod_data}, {7'h00, tx_data}, "async pass-through");
		end
		// Level control loops
		current_below_band = 1'b1;
		vsense_below_band = 1'b1;
		cyc(40 * ALC_C);
		chk({3'h0, level_ctrl_out}, 8'h1F, "gain at top");
		vsense_below_band = 1'b0;
		vsense_above_band = 1'b1;
		g0 = level_ctrl_out;
		cyc(5 * ALC_C + 3);
		chk({7'h00, (g0 - level_ctrl_out >= 4) && (g0 - level_ctrl_out <= 6)}, 8'h01, "gain down");
		vsense_above_band = 1'b0;
		vsense_below_band = 1'b1;
		current_above_band = 1'b1;
		current_below_band = 1'b0;
		cyc(4);
		g0 = level_ctrl_out;
		cyc(3 * ALC_C);
		chk({7'h00, level_ctrl_out < g0}, 8'h01, "current overrides voltage");
		current_above_band = 1'b0;
		cyc(4);
		g0 = level_ctrl_out;
		cyc(3 * ALC_C);
		chk({3'h0, level_ctrl_out}, {3'h0, g0}, "gain held in current band");
		reg_select = 1'b1;
		cyc(6);
		chk({7'h00, modulator_en}, 8'h00, "modulator off in register access");
		reg_select = 1'b0;
		direction_select = 1'b1;
		cyc(6);
		chk({7'h00, modulator_en}, 8'h00, "modulator off in receive");
		$display("test transmit done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
